// *** verilog/nand_copyback_host.sv ***
// Purpose: host controller driving a two-plane flash over its 8-bit bus
// Assumes: ready/busy pulled up externally; all inputs synchronous
// Notes:   software starts one operation at a time through REG_CTRL
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module nand_copyback_host #(
  parameter int PWRUP_WAIT = nand_host_pkg::PWRUP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  output logic             cmdLatch,
  output logic             addrLatch,
  output logic             chipSel_n,
  output logic             writeStrobe_n,
  output logic             output_strobe_n,
  output logic             writeGuard_n,
  output logic      [7:0]  ioOut,
  output logic             ioOe,
  input  wire logic [7:0]  ioIn,
  input  wire logic        ready_busy_wire
);
  import nand_host_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_STROBE, S_RECOVER, S_TWB, S_WAITRB
  } state_e;

  state_e      stateQ;
  logic [2:0]  opQ;
  logic [7:0]  byteQ;
  logic        resumeQ;
  logic [4:0]  stepQ;
  logic [15:0] cntQ;
  logic [23:0] srcRowQ;
  logic [23:0] dstRowQ;
  logic [7:0]  rdByteQ;
  logic [7:0]  statusQ;
  logic [7:0]  idQ [ID_BYTES];
  logic [2:0]  idxQ;
  logic        guardEnQ;
  logic        refusedQ;
  logic        statusModeQ;
  logic [31:0] pwrCntQ;
  logic        pwrReadyQ;
  logic        readOpQ;

  // one step of the current operation: kind and byte
  function automatic logic [10:0] stepOf(input logic [2:0] op,
                                         input logic [4:0] idx,
                                         input logic [7:0] b,
                                         input logic [23:0] src,
                                         input logic [23:0] dst,
                                         input logic resume);
    logic [4:0] i;
    logic [10:0] s;
    i = idx;
    s = {K_END, 8'h00};
    case (op)
      OP_CMD:   if (i == 5'd0) s = {K_CMD, b};
      OP_ADDR:  if (i == 5'd0) s = {K_ADDR, b};
      OP_WDATA: if (i == 5'd0) s = {K_WR, b};
      OP_RDATA: begin
        if (!resume) i = idx + 5'd1;
        if (i == 5'd0) s = {K_CMD, FC_READ};
        else if (i == 5'd1) s = {K_RD, 8'h00};
      end
      OP_RESET: begin
        if (i == 5'd0) s = {K_CMD, FC_RESET};
        else if (i == 5'd1) s = {K_WAIT, 8'h00};
      end
      OP_STATUS: begin
        if (i == 5'd0) s = {K_CMD, FC_STATUS};
        else if (i == 5'd1) s = {K_RD, 8'h00};
      end
      OP_ID: begin
        if (i == 5'd0) s = {K_CMD, FC_ID};
        else if (i == 5'd1) s = {K_ADDR, ID_ADDR};
        else if (i <= 5'd6) s = {K_RD, 8'h00};
      end
      OP_COPY: begin
        case (i)
          5'd0:  s = {K_CMD, FC_READ};
          5'd1:  s = {K_ADDR, COL_START};
          5'd2:  s = {K_ADDR, COL_START};
          5'd3:  s = {K_ADDR, src[7:0]};
          5'd4:  s = {K_ADDR, src[15:8]};
          5'd5:  s = {K_ADDR, src[23:16]};
          5'd6:  s = {K_CMD, FC_COPYRD};
          5'd7:  s = {K_WAIT, 8'h00};
          5'd8:  s = {K_CMD, FC_COPYIN};
          5'd9:  s = {K_ADDR, COL_START};
          5'd10: s = {K_ADDR, COL_START};
          5'd11: s = {K_ADDR, dst[7:0]};
          5'd12: s = {K_ADDR, dst[15:8]};
          5'd13: s = {K_ADDR, dst[23:16]};
          5'd14: s = {K_CMD, FC_CONFIRM};
          5'd15: s = {K_WAIT, 8'h00};
          5'd16: s = {K_CMD, FC_STATUS};
          5'd17: s = {K_RD, 8'h00};
          default: s = {K_END, 8'h00};
        endcase
      end
      default: s = {K_END, 8'h00};
    endcase
    return s;
  endfunction

  logic [10:0] curStep;
  logic [2:0]  curKind;
  logic [7:0]  curByte;
  assign curStep = stepOf(opQ, stepQ, byteQ, srcRowQ, dstRowQ, resumeQ);
  assign curKind = curStep[10:8];
  assign curByte = curStep[7:0];

  // start decode and host-side guards
  logic       ctrlWrite;
  logic [2:0] newOp;
  logic [7:0] newByte;
  logic       busyOk;
  logic       startOk;
  assign ctrlWrite = regWrite && regAddr == REG_CTRL;
  assign newOp     = regWdata[CTRL_OP_LSB +: 3];
  assign newByte   = regWdata[CTRL_BYTE_LSB +: 8];
  // while the device is busy only status polling, reset and plain (not resumed) reads may go out
  always_comb begin
    case (newOp)
      OP_STATUS, OP_RESET: busyOk = 1'b1;
      // a resumed read would put 00h on the bus while busy
      OP_RDATA: busyOk = !regWdata[CTRL_RESUME];
      OP_CMD:  busyOk = newByte == FC_STATUS || newByte == FC_RESET;
      default: busyOk = 1'b0;
    endcase
  end
  assign startOk = stateQ == S_IDLE && pwrReadyQ
                   && (ready_busy_wire || busyOk)
                   && !(newOp == OP_COPY
                        && srcRowQ[PLANE_BIT] != dstRowQ[PLANE_BIT]);

  // power-up recovery before any command
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwrCntQ   <= 32'h0;
      pwrReadyQ <= 1'b0;
    end else if (!pwrReadyQ) begin
      pwrCntQ   <= pwrCntQ + 32'h1;
      pwrReadyQ <= pwrCntQ >= 32'(PWRUP_WAIT - 1);
    end
  end

  // write guard stays low until recovery is over and software allows it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      writeGuard_n <= 1'b0;
    end else begin
      writeGuard_n <= guardEnQ && pwrReadyQ;
    end
  end

  // software registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      guardEnQ <= 1'b0;
      srcRowQ  <= 24'h0;
      dstRowQ  <= 24'h0;
      refusedQ <= 1'b0;
    end else if (regWrite) begin
      case (regAddr)
        REG_GUARD:  guardEnQ <= regWdata[0];
        REG_SRCROW: srcRowQ  <= regWdata[23:0];
        REG_DSTROW: dstRowQ  <= regWdata[23:0];
        REG_CTRL:   refusedQ <= !startOk;
        default:    refusedQ <= refusedQ;
      endcase
    end
  end

  // sequencing engine and flash pins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stateQ          <= S_IDLE;
      opQ             <= OP_CMD;
      byteQ           <= 8'h00;
      resumeQ         <= 1'b0;
      stepQ           <= 5'd0;
      cntQ            <= 16'h0;
      cmdLatch        <= 1'b0;
      addrLatch       <= 1'b0;
      chipSel_n       <= 1'b1;
      writeStrobe_n   <= 1'b1;
      output_strobe_n <= 1'b1;
      ioOut           <= 8'h00;
      ioOe            <= 1'b0;
      readOpQ         <= 1'b0;
    end else begin
      case (stateQ)
        S_IDLE: begin
          chipSel_n <= 1'b1;
          ioOe      <= 1'b0;
          if (ctrlWrite && startOk) begin
            opQ       <= newOp;
            byteQ     <= newByte;
            resumeQ   <= regWdata[CTRL_RESUME] && statusModeQ;
            stepQ     <= 5'd0;
            chipSel_n <= 1'b0;
            stateQ    <= S_SETUP;
          end
        end
        S_SETUP: begin
          cmdLatch  <= curKind == K_CMD;
          addrLatch <= curKind == K_ADDR;
          ioOut     <= curByte;
          ioOe      <= curKind == K_CMD || curKind == K_ADDR
                       || curKind == K_WR;
          readOpQ   <= curKind == K_RD;
          cntQ      <= 16'(PULSE_CYC - 1);
          case (curKind)
            K_CMD, K_ADDR, K_WR: begin
              writeStrobe_n <= 1'b0;
              stateQ        <= S_STROBE;
            end
            K_RD: begin
              output_strobe_n <= 1'b0;
              stateQ          <= S_STROBE;
            end
            K_WAIT: begin
              cntQ   <= 16'(TWB_CYC - 1);
              stateQ <= S_TWB;
            end
            default: stateQ <= S_IDLE;
          endcase
        end
        S_STROBE: begin
          if (cntQ == 16'h0) begin
            writeStrobe_n   <= 1'b1;
            output_strobe_n <= 1'b1;
            cntQ            <= 16'(HOLD_CYC - 1);
            stateQ          <= S_RECOVER;
          end else begin
            cntQ <= cntQ - 16'h1;
          end
        end
        S_RECOVER: begin
          if (cntQ == 16'h0) begin
            cmdLatch  <= 1'b0;
            addrLatch <= 1'b0;
            stateQ    <= S_SETUP;
            // status polling repeats the read alone until ready shows
            if (!(opQ == OP_STATUS && readOpQ && !rdByteQ[STAT_READY]))
              stepQ <= stepQ + 5'd1;
          end else begin
            cntQ <= cntQ - 16'h1;
          end
        end
        S_TWB: begin
          // busy is not valid until the write-to-busy delay has passed
          if (cntQ == 16'h0) stateQ <= S_WAITRB;
          else cntQ <= cntQ - 16'h1;
        end
        S_WAITRB: begin
          if (ready_busy_wire) begin
            stepQ  <= stepQ + 5'd1;
            stateQ <= S_SETUP;
          end
        end
        default: stateQ <= S_IDLE;
      endcase
    end
  end

  // read capture at the last cycle of the strobe low time
  logic capture;
  assign capture = stateQ == S_STROBE && readOpQ && cntQ == 16'h0;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdByteQ <= 8'h00;
      statusQ <= 8'h00;
      idxQ    <= 3'd0;
      for (int k = 0; k < ID_BYTES; k++) idQ[k] <= 8'h00;
    end else begin
      if (stateQ == S_IDLE && ctrlWrite && startOk) idxQ <= 3'd0;
      if (capture) begin
        rdByteQ <= ioIn;
        // in status mode every read returns the status byte
        if (statusModeQ || opQ == OP_STATUS || opQ == OP_COPY)
          statusQ <= ioIn;
        if (opQ == OP_ID && idxQ < 3'(ID_BYTES)) begin
          idQ[idxQ] <= ioIn;
          idxQ      <= idxQ + 3'd1;
        end
      end
    end
  end

  // tracks whether the last command put the device in status mode
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      statusModeQ <= 1'b0;
    end else if (stateQ == S_SETUP && curKind == K_CMD) begin
      statusModeQ <= curByte == FC_STATUS;
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 32'h0;
    end else if (regRead) begin
      case (regAddr)
        REG_CTRL:   regRdata <= {24'h0, statusQ[2:0],
                                 pwrReadyQ, writeGuard_n, ready_busy_wire,
                                 refusedQ, stateQ != S_IDLE};
        REG_GUARD:  regRdata <= {31'h0, guardEnQ};
        REG_SRCROW: regRdata <= {8'h0, srcRowQ};
        REG_DSTROW: regRdata <= {8'h0, dstRowQ};
        REG_RDBYTE: regRdata <= {24'h0, rdByteQ};
        REG_STATUS: regRdata <= {24'h0, statusQ};
        REG_IDLOW:  regRdata <= {idQ[3], idQ[2], idQ[1], idQ[0]};
        REG_IDHIGH: regRdata <= {24'h0, idQ[4]};
        default:    regRdata <= 32'h0;
      endcase
    end else begin
      regRdata <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// *** verilog/nand_host_pkg.sv ***
// Purpose: constants of the copy-back / status / id / reset flash host
// Assumes: 250 MHz ref_clk, 8-bit multiplexed flash bus
// Notes:   register offsets are word indices on the plain command port
package nand_host_pkg;
  // register indices on the command port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_GUARD  = 4'h1;
  localparam logic [3:0] REG_SRCROW = 4'h2;
  localparam logic [3:0] REG_DSTROW = 4'h3;
  localparam logic [3:0] REG_RDBYTE = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_IDLOW  = 4'h6;
  localparam logic [3:0] REG_IDHIGH = 4'h7;
  // control word fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_BYTE_LSB = 8;
  localparam int CTRL_RESUME   = 16;
  // operations
  localparam logic [2:0] OP_CMD    = 3'h0;
  localparam logic [2:0] OP_ADDR   = 3'h1;
  localparam logic [2:0] OP_WDATA  = 3'h2;
  localparam logic [2:0] OP_RDATA  = 3'h3;
  localparam logic [2:0] OP_RESET  = 3'h4;
  localparam logic [2:0] OP_STATUS = 3'h5;
  localparam logic [2:0] OP_ID     = 3'h6;
  localparam logic [2:0] OP_COPY   = 3'h7;
  // flash command and address bytes, id length, status and plane bits
  localparam logic [7:0] FC_READ     = 8'h00;
  localparam logic [7:0] FC_COPYRD   = 8'h35;
  localparam logic [7:0] FC_COPYIN   = 8'h85;
  localparam logic [7:0] FC_CONFIRM  = 8'h10;
  localparam logic [7:0] FC_STATUS   = 8'h70;
  localparam logic [7:0] FC_ID       = 8'h90;
  localparam logic [7:0] FC_RESET    = 8'hff;
  localparam logic [7:0] ID_ADDR     = 8'h00;
  localparam logic [7:0] COL_START   = 8'h00;
  localparam int         ID_BYTES    = 5;
  localparam int         STAT_READY  = 6;
  localparam int         PLANE_BIT   = 7;
  // step kinds
  localparam logic [2:0] K_END  = 3'h0;
  localparam logic [2:0] K_CMD  = 3'h1;
  localparam logic [2:0] K_ADDR = 3'h2;
  localparam logic [2:0] K_WR   = 3'h3;
  localparam logic [2:0] K_RD   = 3'h4;
  localparam logic [2:0] K_WAIT = 3'h5;
  // timing
  localparam int CLK_NS   = 4;
  localparam int PULSE_NS = 15;
  localparam int HOLD_NS  = 10;
  localparam int TWB_NS   = 100;
  localparam int PWRUP_US = 100;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC  = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWB_CYC   = (TWB_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_CYC = (PWRUP_US * 1000 + CLK_NS - 1) / CLK_NS;
endpackage

// *** sim/nand_copyback_host_assertions.sv ***
// Purpose: port-level checks of the copy-back flash host
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every host instance below
`timescale 1ns/1ps
`default_nettype none
module nand_copyback_host_checker #(
  parameter int PWRUP_WAIT = 20
) (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        cmdLatch,
  input wire logic        addrLatch,
  input wire logic        chipSel_n,
  input wire logic        writeStrobe_n,
  input wire logic        output_strobe_n,
  input wire logic        writeGuard_n,
  input wire logic [7:0]  ioOut,
  input wire logic        ioOe,
  input wire logic [7:0]  ioIn,
  input wire logic        ready_busy_wire
);
  int upCnt_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      upCnt_q <= 0;
    else if (upCnt_q < PWRUP_WAIT)
      upCnt_q <= upCnt_q + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  AST_PWRUP_IDLE: assert property (upCnt_q < PWRUP_WAIT |-> chipSel_n)
    else $error("flash selected during power recovery");
  AST_GUARD_PWRUP: assert property (upCnt_q < PWRUP_WAIT |-> !writeGuard_n)
    else $error("write guard released during power recovery");
  AST_WR_WIDTH: assert property ($fell(writeStrobe_n) |->
    !writeStrobe_n [*4] ##1 writeStrobe_n) else $error("write pulse width");
  AST_RD_WIDTH: assert property ($fell(output_strobe_n) |->
    !output_strobe_n [*4] ##1 output_strobe_n) else $error("read pulse width");
  AST_WR_HOLD: assert property ($rose(writeStrobe_n) |->
    ($stable(ioOut) && $stable(cmdLatch) && $stable(addrLatch)) [*3])
    else $error("bus changed inside hold time");
  AST_STROBE_CS: assert property (
    !writeStrobe_n || !output_strobe_n |-> !chipSel_n)
    else $error("strobe without chip select");
  AST_DRIVE_WRITE: assert property (
    !writeStrobe_n |-> ioOe && !(cmdLatch && addrLatch))
    else $error("write cycle without bus drive");
  AST_FLOAT_READ: assert property (
    !output_strobe_n |-> !ioOe && !cmdLatch && !addrLatch)
    else $error("host drives bus in read cycle");
  AST_BUSY_CMDS: assert property (
    $fell(writeStrobe_n) && cmdLatch && !ready_busy_wire
    |-> ioOut inside {8'h70, 8'hff}) else $error("command sent while busy");
  AST_RDATA_SLOT: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside its slot");
endmodule
bind nand_copyback_host nand_copyback_host_checker #(
  .PWRUP_WAIT(PWRUP_WAIT)
) chk_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
  .chipSel_n(chipSel_n), .writeStrobe_n(writeStrobe_n),
  .output_strobe_n(output_strobe_n), .writeGuard_n(writeGuard_n),
  .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn),
  .ready_busy_wire(ready_busy_wire)
);
`default_nettype wire

// *** sim/flash_device_model.sv ***
// Purpose: behavioural two-plane flash seen from its 8-bit bus
// Assumes: commands sampled on the rising write strobe
// Notes:   busy times shortened; only copy, status, id, reset modelled
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
  parameter logic [39:0] SIG_BYTES = 40'h44_33_22_11_5a, // arbitrary codes
  parameter int          BUSY_NS   = 400
) (
  input  wire logic       chipSel_n,
  input  wire logic       cmdLatch,
  input  wire logic       addrLatch,
  input  wire logic       writeStrobe_n,
  input  wire logic       output_strobe_n,
  input  wire logic       writeGuard_n,
  input  wire logic [7:0] ioOut,
  input  wire logic       failNext,
  output logic      [7:0] ioIn,
  output logic            busyDrive,
  output logic            crossPlane
);
  logic [7:0] cmd = 8'h00;
  logic [7:0] lastOut = 8'h00;
  logic [7:0] addr [0:4];
  logic [2:0] aCnt = 3'h0;
  logic [2:0] idIdx = 3'h0;
  logic [2:0] fail = 3'h0;
  logic       resetting = 1'b0;
  logic       srcPlane = 1'b0;
  logic [7:0] stat;
  logic [7:0] outVal;
  logic [7:0] pageBuf [0:3];
  logic       pwrOk = 1'b0;
  // supply detector keeps the array locked for a short while after power-on
  initial #40 pwrOk = 1'b1;
  initial busyDrive = 1'b0;
  initial crossPlane = 1'b0;
  assign stat = {writeGuard_n, ~busyDrive, ~busyDrive, 2'b00, fail};
  assign outVal = (cmd == 8'h70) ? stat :
    (cmd == 8'h90) ? SIG_BYTES[8*idIdx +: 8] :
    (cmd == 8'h00) ? pageBuf[addr[0][1:0]] : 8'hc3;
  // released bus shows the inverse of the last byte, not a stale copy
  assign ioIn = (!chipSel_n && !output_strobe_n) ? outVal : ~lastOut;
  always @(posedge output_strobe_n) begin
    if (!chipSel_n) begin
      lastOut = outVal;
      if (cmd == 8'h90 && idIdx < 3'd4)
        idIdx = idIdx + 3'd1;
    end
  end
  always @(posedge writeStrobe_n) begin
    if (!chipSel_n && addrLatch && aCnt < 3'd5) begin
      addr[aCnt] = ioOut;
      aCnt = aCnt + 3'd1;
    end
    // a data cycle lands at the current column of the page buffer
    if (!chipSel_n && !cmdLatch && !addrLatch)
      pageBuf[addr[0][1:0]] = ioOut;
    // while busy only status and a first reset get through
    if (pwrOk && !chipSel_n && cmdLatch && (!busyDrive || ioOut == 8'h70 ||
        (ioOut == 8'hff && !resetting))) begin
      cmd = ioOut;
      aCnt = 3'd0;
      idIdx = 3'd0;
      if (ioOut == 8'h35)
        srcPlane = addr[2][7];
      if (ioOut == 8'h10) begin
        crossPlane = crossPlane | (addr[2][7] != srcPlane);
        fail = failNext ? {addr[2][7], ~addr[2][7], 1'b1} : 3'b000;
      end
      if (ioOut == 8'hff) begin
        fail = 3'b000;
        resetting = 1'b1;
      end
      if (ioOut inside {8'h35, 8'h10, 8'hff}) begin
        fork
          begin
            // kept off the clock edge so the host never races the pin
            #18 busyDrive = 1'b1;
            #BUSY_NS busyDrive = 1'b0;
            resetting = 1'b0;
          end
        join_none
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Purpose: self-checking bench of the copy-back flash host
// Assumes: device model on the flash bus, pull-up on ready/busy
// Notes:   power recovery shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
  import nand_host_pkg::*;
  localparam logic [39:0] SIG = 40'h4d_3c_2b_1a_6e; // arbitrary codes
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic        failNext = 1'b0;
  logic [31:0] regRdata;
  logic        cmdLatch, addrLatch, chipSel_n, writeStrobe_n;
  logic        output_strobe_n, writeGuard_n, ioOe, busyDrive, crossPlane;
  logic [7:0]  ioOut, ioIn;
  wire logic   ready_busy_wire;
  int          fails = 0;
  int          n_checks = 0;
  assign ready_busy_wire = busyDrive ? 1'b0 : 1'b1;
  always #2 ref_clk = ~ref_clk;
  nand_copyback_host #(.PWRUP_WAIT(20)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
    .chipSel_n(chipSel_n), .writeStrobe_n(writeStrobe_n),
    .output_strobe_n(output_strobe_n), .writeGuard_n(writeGuard_n),
    .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn),
    .ready_busy_wire(ready_busy_wire));
  flash_device_model #(.SIG_BYTES(SIG)) dev (
    .chipSel_n(chipSel_n), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
    .writeStrobe_n(writeStrobe_n), .output_strobe_n(output_strobe_n),
    .writeGuard_n(writeGuard_n), .ioOut(ioOut), .failNext(failNext),
    .ioIn(ioIn), .busyDrive(busyDrive), .crossPlane(crossPlane));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  // start one operation and poll the engine until it is idle again
  task automatic op(input logic [31:0] c, output logic [31:0] st);
    int i;
    wr(REG_CTRL, c);
    for (i = 0; i < 3000; i++) begin
      rd(REG_CTRL, st);
      if (st[0] === 1'b0)
        break;
    end
    if (i == 3000) begin
      fails++;
      end_of_test();
    end
  endtask
  function automatic logic [7:0] exp_copy(input logic f, input logic pl);
    return {f & pl, f & ~pl, f, 5'b11100};
  endfunction
  initial begin
    logic [31:0] v;
    logic [23:0] s, d;
    logic [7:0]  w;
    int k;
    void'($urandom(86));
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(REG_CTRL, v);
    chk(v[4:0], 5'b00100);
    wr(REG_CTRL, {29'h0, OP_ID});
    rd(REG_CTRL, v);
    chk(v[1:0], 2'b10);
    repeat (20) @(posedge ref_clk);
    wr(REG_GUARD, 32'h1);
    op({29'h0, OP_RESET}, v);
    chk(v[4:0], 5'b11100);
    // bare reset command: the engine goes idle without waiting for the flash, which then goes busy
    op({16'h0, FC_RESET, 5'h0, OP_CMD}, v);
    wr(REG_CTRL, {29'h0, OP_ID});
    rd(REG_CTRL, v);
    chk(v[2:0], 3'b010);
    op({29'h0, OP_STATUS}, v);
    rd(REG_STATUS, v);
    chk(v[7:0], 8'he0);
    op({29'h0, OP_RDATA}, v);
    rd(REG_RDBYTE, v);
    chk(v[7:0], 8'he0);
    op({29'h0, OP_ID}, v);
    rd(REG_IDLOW, v);
    chk(v, SIG[31:0]);
    rd(REG_IDHIGH, v);
    chk(v[7:0], SIG[39:32]);
    op({29'h0, OP_RDATA}, v);
    rd(REG_RDBYTE, v);
    chk(v[7:0], SIG[39:32]);
    for (k = 0; k < 4; k++) begin
      s = 24'($urandom);
      d = 24'($urandom);
      d[7] = s[7];
      failNext <= k[0];
      wr(REG_SRCROW, {8'h0, s});
      wr(REG_DSTROW, {8'h0, d});
      op({29'h0, OP_COPY}, v);
      chk(v[7:0], exp_copy(k[0], d[7]));
    end
    // random data input into the buffer, then a resumed read after polling
    w = 8'($urandom) | 8'h08;
    op({16'h0, FC_COPYIN, 5'h0, OP_CMD}, v);
    op({16'h0, 8'h02, 5'h0, OP_ADDR}, v);
    op({16'h0, 8'h00, 5'h0, OP_ADDR}, v);
    op({16'h0, w, 5'h0, OP_WDATA}, v);
    op({29'h0, OP_STATUS}, v);
    op({15'h0, 1'b1, FC_READ, 5'h0, OP_RDATA}, v);
    rd(REG_RDBYTE, v);
    chk(v[7:0], w);
    wr(REG_DSTROW, {8'h0, ~s});
    wr(REG_CTRL, {29'h0, OP_COPY});
    rd(REG_CTRL, v);
    chk(v[1:0], 2'b10);
    chk(crossPlane, 1'b0);
    rd(4'hf, v);
    chk(v, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
